// ---- verilog/cpcfg_pkg.sv ----
package cpcfg_pkg;
	// register offsets
	localparam logic [9:0] CPCFG_LOOP_CTRL_ADDR = 10'h010;
	localparam logic [9:0] CPCFG_CAL_CTRL_ADDR = 10'h018;
	localparam logic [9:0] CPCFG_REF_EN_ADDR = 10'h01C;
	localparam logic [9:0] CPCFG_DIV_RATIO_ADDR = 10'h1E0;
	localparam logic [9:0] CPCFG_SRC_SEL_ADDR = 10'h1E1;
	localparam logic [9:0] CPCFG_UPDATE_ADDR = 10'h232;
	localparam logic [9:0] CPCFG_NV_CTRL_ADDR = 10'h3F0;
	localparam logic [9:0] CPCFG_STATUS_ADDR = 10'h3F1;
	// field positions
	localparam int CPCFG_POL_BIT = 7;
	localparam int CPCFG_CAL_BIT = 0;
	localparam int CPCFG_BYP_BIT = 0;
	localparam int CPCFG_SRC_BIT = 1;
	localparam int CPCFG_UPD_BIT = 0;
	localparam int CPCFG_NV_SAVE_BIT = 0;
	localparam int CPCFG_FIELD_LSB = 0;
	localparam int CPCFG_LOOP_MSB = 1;
	localparam int CPCFG_RATIO_MSB = 2;
	localparam int CPCFG_REF_MSB = 2;
	// loop power control codes
	localparam logic [1:0] CPCFG_LOOP_NORMAL = 2'h0;
	localparam logic [1:0] CPCFG_LOOP_PDOWN = 2'h1;
	// reset values
	localparam logic [7:0] CPCFG_LOOP_CTRL_RST = 8'h01;
	localparam logic [7:0] CPCFG_CAL_CTRL_RST = 8'h00;
	localparam logic [7:0] CPCFG_REF_EN_RST = 8'h00;
	localparam logic [7:0] CPCFG_DIV_RATIO_RST = 8'h00;
	localparam logic [7:0] CPCFG_SRC_SEL_RST = 8'h00;
	localparam logic [7:0] CPCFG_ZERO = 8'h00;
	// divider code to ratio map
	localparam logic [2:0] CPCFG_DIV_CODE_TWO = 3'h0;
	localparam logic [2:0] CPCFG_DIV_MAX = 3'h6;
	localparam logic [2:0] CPCFG_DIV_TWO = 3'h2;
	localparam int CPCFG_NREG = 5;
endpackage

// ---- verilog/cpcfg_top.sv ----
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
// Contract
// - loop field 00 runs the loop normally, 01 powers it down.
// - source bit 1 selects internal oscillator, 0 selects external clock.
// - bypass bit 0 uses divider output, 1 passes source straight through.
// - reset gives loop off, ratio code 000, divider used, external clock.
// - calibrate bit set then update strobe starts oscillator calibration; the code starts it only when the active bit was 0.
// - polarity bit 0 positive, 1 negative.
// - external source with loop on keeps oscillator off, feeds prescaler.
// - configuration can be saved to nonvolatile store, restored at power-up.
// - reference inputs are disabled after power-up until enabled; the code restores saved enables from a valid store image.
module cpcfg_top
	import cpcfg_pkg::*;
#(
	parameter int ADDR_W = 10,
	parameter int DATA_W = 8
)
(
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	output logic [1:0] loop_power_out,
	output logic loop_enable_out,
	output logic pfd_negative_out,
	output logic osc_select_out,
	output logic osc_power_out,
	output logic ext_to_prescaler_out,
	output logic div_bypass_out,
	output logic [2:0] div_ratio_out,
	output logic [2:0] ref_enable_out,
	output logic cal_start_out,
	output logic [DATA_W-1:0] nv_wdata_out,
	output logic [2:0] nv_waddr_out,
	output logic nv_we_out
);

	// staged registers
	logic [DATA_W-1:0] stg_loop_r;
	logic [DATA_W-1:0] stg_cal_r;
	logic [DATA_W-1:0] stg_ref_r;
	logic [DATA_W-1:0] stg_div_r;
	logic [DATA_W-1:0] stg_src_r;
	// active registers
	logic [DATA_W-1:0] act_loop_r;
	logic [DATA_W-1:0] act_cal_r;
	logic [DATA_W-1:0] act_ref_r;
	logic [DATA_W-1:0] act_div_r;
	logic [DATA_W-1:0] act_src_r;
	// nonvolatile store image
	logic [DATA_W-1:0] nv_mem_r [CPCFG_NREG];
	logic nv_valid_r;
	logic restore_done_r;
	logic [2:0] save_idx_r;
	logic saving_r;
	logic wr_upd;
	logic wr_save;
	logic [DATA_W-1:0] rdata_nxt;

	// maps a ratio code to the effective ratio
	function automatic logic [2:0] cpcfg_ratio(input logic [2:0] code);
		if (code == CPCFG_DIV_CODE_TWO || code > CPCFG_DIV_MAX)
			return CPCFG_DIV_TWO;
		return code;
	endfunction

	// address match helper
	function automatic logic cpcfg_hit(input logic [ADDR_W-1:0] a, input logic [9:0] r);
		return a == ADDR_W'(r);
	endfunction

	// loop power field decodes to normal operation
	function automatic logic cpcfg_loop_on(input logic [DATA_W-1:0] v);
		return v[CPCFG_LOOP_MSB:CPCFG_FIELD_LSB] == CPCFG_LOOP_NORMAL;
	endfunction

	assign wr_upd = reg_wr_in && cpcfg_hit(reg_addr_in, CPCFG_UPDATE_ADDR)
		&& reg_wdata_in[CPCFG_UPD_BIT];
	assign wr_save = reg_wr_in && cpcfg_hit(reg_addr_in, CPCFG_NV_CTRL_ADDR)
		&& reg_wdata_in[CPCFG_NV_SAVE_BIT] && !saving_r;

	// staging writes, held until update
	// staged writes only
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			stg_loop_r <= CPCFG_LOOP_CTRL_RST;
			stg_cal_r <= CPCFG_CAL_CTRL_RST;
			stg_ref_r <= CPCFG_REF_EN_RST;
			stg_div_r <= CPCFG_DIV_RATIO_RST;
			stg_src_r <= CPCFG_SRC_SEL_RST;
		end
		else if (!restore_done_r)
		begin
			if (nv_valid_r)
			begin
				stg_loop_r <= nv_mem_r[0];
				stg_cal_r <= nv_mem_r[1];
				stg_ref_r <= nv_mem_r[2];
				stg_div_r <= nv_mem_r[3];
				stg_src_r <= nv_mem_r[4];
			end
		end
		else if (reg_wr_in)
		begin
			if (cpcfg_hit(reg_addr_in, CPCFG_LOOP_CTRL_ADDR))
				stg_loop_r <= reg_wdata_in;
			if (cpcfg_hit(reg_addr_in, CPCFG_CAL_CTRL_ADDR))
				stg_cal_r <= reg_wdata_in;
			if (cpcfg_hit(reg_addr_in, CPCFG_REF_EN_ADDR))
				stg_ref_r <= reg_wdata_in;
			if (cpcfg_hit(reg_addr_in, CPCFG_DIV_RATIO_ADDR))
				stg_div_r <= reg_wdata_in;
			if (cpcfg_hit(reg_addr_in, CPCFG_SRC_SEL_ADDR))
				stg_src_r <= reg_wdata_in;
		end
	end

	// active copy on update, or restore from store
	// reset defaults
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			act_loop_r <= CPCFG_LOOP_CTRL_RST;
			act_cal_r <= CPCFG_CAL_CTRL_RST;
			act_ref_r <= CPCFG_REF_EN_RST;
			act_div_r <= CPCFG_DIV_RATIO_RST;
			act_src_r <= CPCFG_SRC_SEL_RST;
		end
		else if (!restore_done_r)
		begin
			if (nv_valid_r)
			begin
				act_loop_r <= nv_mem_r[0];
				act_cal_r <= nv_mem_r[1];
				act_ref_r <= nv_mem_r[2];
				act_div_r <= nv_mem_r[3];
				act_src_r <= nv_mem_r[4];
			end
		end
		else if (wr_upd)
		begin
			act_loop_r <= stg_loop_r;
			act_cal_r <= stg_cal_r;
			act_ref_r <= stg_ref_r;
			act_div_r <= stg_div_r;
			act_src_r <= stg_src_r;
		end
	end

	// restore runs once, first cycle after reset release
	// blocks staged writes and update strobes while the stored words are copied
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			restore_done_r <= 1'b0;
		else
			restore_done_r <= 1'b1;
	end

	// nonvolatile store: survives reset_n_in, cleared never by it
	// save sequence
	always_ff @(posedge sys_clk_in)
	begin
		if (saving_r)
			nv_mem_r[save_idx_r] <= nv_wdata_out;
	end

	// save sequencer walks the active registers
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			saving_r <= 1'b0;
			save_idx_r <= 3'h0;
		end
		else if (wr_save)
		begin
			saving_r <= 1'b1;
			save_idx_r <= 3'h0;
		end
		else if (saving_r)
		begin
			if (save_idx_r == 3'(CPCFG_NREG - 1))
				saving_r <= 1'b0;
			else
				save_idx_r <= save_idx_r + 3'h1;
		end
	end

	// store valid flag, power-on cleared only by the store itself
	// no reset: the store image must outlive reset_n_in
	always_ff @(posedge sys_clk_in)
	begin
		if (saving_r && save_idx_r == 3'(CPCFG_NREG - 1))
			nv_valid_r <= 1'b1;
		else if (nv_valid_r !== 1'b1)
			nv_valid_r <= 1'b0;
	end

	// store write port mirrors
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			nv_wdata_out <= CPCFG_ZERO;
			nv_waddr_out <= 3'h0;
			nv_we_out <= 1'b0;
		end
		else
		begin
			nv_we_out <= wr_save || (saving_r && save_idx_r != 3'(CPCFG_NREG - 1));
			nv_waddr_out <= wr_save ? 3'h0 : save_idx_r + 3'h1;
			case (wr_save ? 3'h0 : save_idx_r + 3'h1)
				3'h0: nv_wdata_out <= act_loop_r;
				3'h1: nv_wdata_out <= act_cal_r;
				3'h2: nv_wdata_out <= act_ref_r;
				3'h3: nv_wdata_out <= act_div_r;
				3'h4: nv_wdata_out <= act_src_r;
				default: nv_wdata_out <= CPCFG_ZERO;
			endcase
		end
	end

	// read mux returns staged values and status
	always_comb
	begin
		rdata_nxt = CPCFG_ZERO;
		if (reg_addr_in == ADDR_W'(CPCFG_LOOP_CTRL_ADDR))
			rdata_nxt = stg_loop_r;
		else if (reg_addr_in == ADDR_W'(CPCFG_CAL_CTRL_ADDR))
			rdata_nxt = stg_cal_r;
		else if (reg_addr_in == ADDR_W'(CPCFG_REF_EN_ADDR))
			rdata_nxt = stg_ref_r;
		else if (reg_addr_in == ADDR_W'(CPCFG_DIV_RATIO_ADDR))
			rdata_nxt = stg_div_r;
		else if (reg_addr_in == ADDR_W'(CPCFG_SRC_SEL_ADDR))
			rdata_nxt = stg_src_r;
		else if (reg_addr_in == ADDR_W'(CPCFG_STATUS_ADDR))
			rdata_nxt = {3'h0, saving_r, nv_valid_r, act_src_r[CPCFG_SRC_BIT],
				act_loop_r[CPCFG_LOOP_MSB:CPCFG_FIELD_LSB]};
	end

	// read data register, one cycle later
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			reg_rdata_out <= CPCFG_ZERO;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_nxt;
		else
			reg_rdata_out <= CPCFG_ZERO;
	end

	// calibration start pulse when an update raises the active calibrate bit
	// only a 0-to-1 step of the active bit fires, hence the clear first
	// calibrate on update
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			cal_start_out <= 1'b0;
		else
			cal_start_out <= restore_done_r && wr_upd && stg_cal_r[CPCFG_CAL_BIT]
				&& !act_cal_r[CPCFG_CAL_BIT];
	end

	// loop power, enable and detector polarity
	// defaults shown in reset
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			loop_power_out <= CPCFG_LOOP_PDOWN;
			loop_enable_out <= 1'b0;
			pfd_negative_out <= 1'b0;
		end
		else
		begin
			loop_power_out <= act_loop_r[CPCFG_LOOP_MSB:CPCFG_FIELD_LSB];
			loop_enable_out <= cpcfg_loop_on(act_loop_r);
			pfd_negative_out <= act_loop_r[CPCFG_POL_BIT];
		end
	end

	// source routing and oscillator power
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			osc_select_out <= 1'b0;
			osc_power_out <= 1'b0;
			ext_to_prescaler_out <= 1'b0;
			div_bypass_out <= 1'b0;
		end
		else
		begin
			osc_select_out <= act_src_r[CPCFG_SRC_BIT];
			osc_power_out <= act_src_r[CPCFG_SRC_BIT];
			ext_to_prescaler_out <= !act_src_r[CPCFG_SRC_BIT]
				&& cpcfg_loop_on(act_loop_r);
			div_bypass_out <= act_src_r[CPCFG_BYP_BIT];
		end
	end

	// divider ratio and reference enables
	always_ff @(posedge sys_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			div_ratio_out <= CPCFG_DIV_TWO;
			ref_enable_out <= 3'h0;
		end
		else
		begin
			div_ratio_out <= cpcfg_ratio(act_div_r[CPCFG_RATIO_MSB:CPCFG_FIELD_LSB]);
			ref_enable_out <= act_ref_r[CPCFG_REF_MSB:CPCFG_FIELD_LSB];
		end
	end

endmodule

// ---- test/cpcfg_props.sv ----
`timescale 1ns/10ps
module cpcfg_props
	import cpcfg_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic [9:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic [1:0] loop_power_out,
	input wire logic loop_enable_out,
	input wire logic pfd_negative_out,
	input wire logic osc_select_out,
	input wire logic osc_power_out,
	input wire logic ext_to_prescaler_out,
	input wire logic div_bypass_out,
	input wire logic [2:0] div_ratio_out,
	input wire logic [2:0] ref_enable_out,
	input wire logic cal_start_out
);
	default clocking dcb @(posedge sys_clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// update strobe write and active config bundle
	logic upd;
	logic [10:0] cfg;
	assign upd = reg_wr_in && reg_addr_in == CPCFG_UPDATE_ADDR && reg_wdata_in[CPCFG_UPD_BIT];
	assign cfg = {loop_power_out, pfd_negative_out, osc_select_out, div_bypass_out,
		div_ratio_out, ref_enable_out};
	chk_loop_enable: assert property (loop_enable_out == (loop_power_out == CPCFG_LOOP_NORMAL))
		else $error("loop enable disagrees with loop field");
	chk_osc_power: assert property (osc_power_out == osc_select_out)
		else $error("oscillator power disagrees with source");
	chk_ext_feed: assert property (ext_to_prescaler_out == (!osc_select_out && loop_enable_out))
		else $error("prescaler feed wrong");
	chk_ratio_range: assert property (div_ratio_out != 3'h0 && div_ratio_out <= CPCFG_DIV_MAX)
		else $error("divider ratio out of range");
	chk_staged_only: assert property (($changed(cfg) && $past(reset_n_in, 3))
		|-> ($past(upd) || $past(upd, 2) || $past(upd, 3)))
		else $error("config changed without update");
	chk_cal_pulse: assert property (cal_start_out |=> !cal_start_out)
		else $error("calibration start longer than one cycle");
	chk_cal_cause: assert property (cal_start_out |-> ($past(upd) || $past(upd, 2)))
		else $error("calibration start without update");
	chk_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == CPCFG_ZERO)
		else $error("read data outside read slot");
endmodule
bind cpcfg_top cpcfg_props u_props (.*);

// ---- test/test_clock_path_pll_mode_config.sv ----
`timescale 1ns/10ps
module test_clock_path_pll_mode_config
	import cpcfg_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [9:0] addr = 10'h000;
	logic [7:0] wd = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata, nvd;
	logic [1:0] lp;
	logic le, pol, sel, opw, ext, byp, cal, nwe;
	logic [2:0] ratio, ref_en, nva;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int cals = 0;
	int nvs = 0;
	logic [7:0] nv_seen [8];
	cpcfg_top u_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.loop_power_out(lp), .loop_enable_out(le), .pfd_negative_out(pol),
		.osc_select_out(sel), .osc_power_out(opw), .ext_to_prescaler_out(ext),
		.div_bypass_out(byp), .div_ratio_out(ratio), .ref_enable_out(ref_en),
		.cal_start_out(cal), .nv_wdata_out(nvd), .nv_waddr_out(nva), .nv_we_out(nwe));
	// clock
	initial
	begin
		forever #4 clk = ~clk;
	end
	// pulse counters and hang limit
	always @(posedge clk)
	begin
		cyc++;
		if (cal === 1'b1)
			cals++;
		if (nwe === 1'b1)
		begin
			nvs++;
			nv_seen[nva] = nvd;
		end
		if (cyc == 5000)
		begin
			fail_count++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic wreg(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [9:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, e);
	endtask
	task automatic upd();
		wreg(CPCFG_UPDATE_ADDR, 8'h01);
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask
	// loop, enable, polarity, source, power, feed, bypass; then ratio, refs
	task automatic cfg(input logic [7:0] e1, input logic [5:0] e2);
		chk({lp, le, pol, sel, opw, ext, byp}, e1);
		chk({2'h0, ratio, ref_en}, {2'h0, e2});
	endtask
	task automatic t_reset();
		@(negedge clk);
		cfg({CPCFG_LOOP_PDOWN, 6'h00}, {CPCFG_DIV_TWO, 3'h0});
		rreg(CPCFG_LOOP_CTRL_ADDR, 8'h01);
	endtask
	task automatic t_stage();
		wreg(CPCFG_LOOP_CTRL_ADDR, 8'h80);
		wreg(CPCFG_SRC_SEL_ADDR, 8'h03);
		wreg(CPCFG_DIV_RATIO_ADDR, 8'h05);
		wreg(CPCFG_REF_EN_ADDR, 8'h07);
		wreg(10'h2AA, 8'hFF);
		repeat (3) @(posedge clk);
		@(negedge clk);
		cfg({CPCFG_LOOP_PDOWN, 6'h00}, {CPCFG_DIV_TWO, 3'h0});
		upd();
		cfg({2'h0, 6'b111101}, {3'h5, 3'h7});
		rreg(CPCFG_SRC_SEL_ADDR, 8'h03);
		rreg(10'h2AA, 8'h00);
		wreg(CPCFG_SRC_SEL_ADDR, 8'h00);
		upd();
		cfg({2'h0, 6'b110010}, {3'h5, 3'h7});
	endtask
	task automatic t_ratio();
		wreg(CPCFG_DIV_RATIO_ADDR, 8'h07);
		upd();
		chk({5'h0, ratio}, 8'h02);
		for (logic [7:0] i = 8'h00; i < 8'h07; i++)
		begin
			wreg(CPCFG_DIV_RATIO_ADDR, i);
			upd();
			chk({5'h0, ratio}, (i == 8'h00) ? 8'h02 : i);
		end
	endtask
	task automatic t_cal();
		int c0;
		c0 = cals;
		wreg(CPCFG_SRC_SEL_ADDR, 8'h02);
		wreg(CPCFG_CAL_CTRL_ADDR, 8'h01);
		upd();
		upd();
		chk(8'(cals - c0), 8'h01);
		wreg(CPCFG_CAL_CTRL_ADDR, 8'h00);
		upd();
		wreg(CPCFG_CAL_CTRL_ADDR, 8'h01);
		upd();
		chk(8'(cals - c0), 8'h02);
	endtask
	task automatic t_save();
		int n0;
		n0 = nvs;
		wreg(CPCFG_NV_CTRL_ADDR, 8'h01);
		repeat (10) @(posedge clk);
		chk(8'(nvs - n0), 8'h05);
		chk(nv_seen[0], 8'h80);
		chk(nv_seen[1], 8'h01);
		chk(nv_seen[2], 8'h07);
		chk(nv_seen[3], 8'h06);
		chk(nv_seen[4], 8'h02);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		cfg({2'h0, 6'b111100}, {3'h6, 3'h7});
		rreg(CPCFG_STATUS_ADDR, 8'h0C);
	endtask
	// main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_stage();
		t_ratio();
		t_cal();
		t_save();
		give_verdict();
	end
endmodule
